// ==== verification/mtls_chk_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module mtls_chk
	import mtls_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire mtls_reg_req_t regReq,
	input wire logic [31:0] regRdData,
	input wire logic regRdValid,
	input wire logic loadFilterEnable,
	input wire logic fullStepStrobe,
	input wire logic [7:0] loadMeasurementValue,
	input wire mtls_lookup_t lookup,
	input wire logic [2:0] stepDelta,
	input wire logic stepValid,
	input wire logic stepInRange
);
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// read of the sample word
	logic histRd;
	assign histRd = regReq.rdEn && regReq.addr == 7'h41;
	////////////////////////////////////////////////////////////////////////
	AST_RD_ANS: assert property (regReq.rdEn |=> regRdValid)
		else $error("read answer missing");
	AST_RD_IDLE: assert property (!regReq.rdEn |=> !regRdValid)
		else $error("read answer without read");
	AST_LK_ANS: assert property (lookup.req |=> stepValid)
		else $error("lookup answer missing");
	AST_LK_IDLE: assert property (!lookup.req |=> !stepValid)
		else $error("lookup answer without lookup");
	AST_NEWEST: assert property (histRd && $past(fullStepStrobe) |=>
		regRdData[7:0] == $past(loadMeasurementValue, 2))
		else $error("newest sample byte wrong");
	AST_FILT_OFF: assert property (histRd && !loadFilterEnable
		&& $past(!loadFilterEnable) |=> regRdData[31:8] == 24'h0)
		else $error("older samples shown with filter off");
	AST_OUT_RANGE: assert property (lookup.req && lookup.entry > 7'h5F |=>
		!stepInRange && stepDelta == $past({1'h0, lookup.slope}) - 3'h1)
		else $error("out of range lookup wrong");
	AST_IN_RANGE: assert property (lookup.req && lookup.entry < 7'h60
		|=> stepInRange)
		else $error("in range lookup not flagged");
	// main scenarios reached
	cover property (histRd && loadFilterEnable);
	cover property (lookup.req && lookup.entry > 7'h5F);
	cover property (regReq.wrEn && regReq.addr == 7'h80);
endmodule : mtls_chk
bind mtls_microstep_table_and_load_samples mtls_chk i_mtls_chk (.core_clk,
	.arst_n, .regReq, .regRdData, .regRdValid, .loadFilterEnable,
	.fullStepStrobe, .loadMeasurementValue, .lookup, .stepDelta, .stepValid,
	.stepInRange);
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import mtls_pkg::*;
;
	// one table row: kind (1 = lookup), address or entry, slope, expected
	typedef struct packed {
		logic k;
		logic [6:0] a;
		logic [1:0] s;
		logic [31:0] e;
	} mtls_row_t;
	logic core_clk, arst_n, fullStepStrobe, loadFilterEnable, rdValid;
	logic stepValid, inRange;
	logic [7:0] meas;
	logic [2:0] delta;
	logic [31:0] rdData, d;
	mtls_reg_req_t req;
	mtls_lookup_t lk;
	int numErrors, cmpCount, cyc;
	mtls_row_t rows [16] = '{'{1'h0,7'h41,2'h0,32'h0},
		'{1'h0,7'h80,2'h0,32'hAAAAB554}, '{1'h0,7'h81,2'h0,32'h4A9554AA},
		'{1'h0,7'h82,2'h0,32'h24492929}, '{1'h0,7'h7F,2'h0,32'h0},
		'{1'h1,7'h0,2'h0,32'h1F}, '{1'h1,7'h0,2'h1,32'h18},
		'{1'h1,7'h0,2'h2,32'h19}, '{1'h1,7'h0,2'h3,32'h1A},
		'{1'h1,7'h2,2'h0,32'h18}, '{1'h1,7'h2,2'h1,32'h19},
		'{1'h1,7'h2,2'h2,32'h1A}, '{1'h1,7'h2,2'h3,32'h1B},
		'{1'h1,7'h20,2'h2,32'h19}, '{1'h1,7'h40,2'h3,32'h1B},
		'{1'h1,7'h60,2'h0,32'h17}};
	mtls_microstep_table_and_load_samples i_mtls_microstep_table_and_load_samples (
		.core_clk(core_clk), .arst_n(arst_n), .regReq(req),
		.regRdData(rdData), .regRdValid(rdValid),
		.loadFilterEnable(loadFilterEnable), .fullStepStrobe(fullStepStrobe),
		.loadMeasurementValue(meas), .lookup(lk), .stepDelta(delta),
		.stepValid(stepValid), .stepInRange(inRange));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmpCount++;
		if (s !== e) begin
			numErrors++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// bus cycles are launched and closed on falling edges
	task automatic rd(input logic [6:0] a, output logic [31:0] q);
		@(negedge core_clk);
		req = '{1'h0, 1'h1, a, 32'h0};
		@(negedge core_clk);
		req = '0;
		chk({31'h0, rdValid}, 32'h1);
		q = rdData;
	endtask : rd
	task automatic wr(input logic [6:0] a, input logic [31:0] v);
		@(negedge core_clk);
		req = '{1'h1, 1'h0, a, v};
		@(negedge core_clk);
		req = '0;
	endtask : wr
	task automatic lku(input logic [6:0] e, input logic [1:0] s,
		output logic [31:0] q);
		@(negedge core_clk);
		lk = '{1'h1, e, s};
		@(negedge core_clk);
		lk = '0;
		q = {27'h0, stepValid, inRange, delta};
	endtask : lku
	task automatic conclude;
		$display("errors %0d compares %0d", numErrors, cmpCount);
		if (numErrors == 0 && cmpCount > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	initial begin
		core_clk = 1'h0;
		forever #2 core_clk = ~core_clk;
	end
	// hang guard, far beyond the roughly 80 cycles needed
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			numErrors++;
			conclude();
		end
	end
	initial begin
		{arst_n, fullStepStrobe, meas, req, lk} = '0;
		loadFilterEnable = 1'h1;
		repeat (20) @(negedge core_clk);
		arst_n = 1'h1;
		foreach (rows[i]) begin
			if (rows[i].k) begin
				lku(rows[i].a, rows[i].s, d);
			end else begin
				rd(rows[i].a, d);
			end
			chk(d, rows[i].e);
		end
		// new words, one to the read-only place; lookup sees the new bit
		wr(7'h80, 32'h00000001);
		wr(7'h81, 32'h5A5A5A5A);
		wr(7'h41, 32'hFFFFFFFF);
		lku(7'h0, 2'h0, d);
		chk(d, 32'h18);
		rd(7'h81, d);
		chk(d, 32'h5A5A5A5A);
		rd(7'h41, d);
		chk(d, 32'h0);
		// back to back measurements with the filter on
		for (int i = 1; i < 5; i++) begin
			@(negedge core_clk);
			fullStepStrobe = 1'h1;
			meas = 8'(i * 17);
		end
		// four steps aged through all bytes, oldest at the top
		@(negedge core_clk);
		fullStepStrobe = 1'h0;
		rd(7'h41, d);
		chk(d, 32'h11223344);
		@(negedge core_clk);
		fullStepStrobe = 1'h1;
		loadFilterEnable = 1'h0;
		meas = 8'h55;
		@(negedge core_clk);
		fullStepStrobe = 1'h0;
		req = '{1'h0, 1'h1, 7'h41, 32'h0};
		@(negedge core_clk);
		req = '0;
		chk(rdData, 32'h00000055);
		loadFilterEnable = 1'h1;
		rd(7'h41, d);
		chk(d, 32'h00000055);
		// reset in mid-run restores the table
		arst_n = 1'h0;
		@(negedge core_clk);
		arst_n = 1'h1;
		rd(7'h80, d);
		chk(d, 32'hAAAAB554);
		rd(7'h41, d);
		chk(d, 32'h0);
		conclude();
	end
endmodule : tb_top
`default_nettype wire

// ==== verilog/mtls_map.svh ====
`ifndef MTLS_MAP_SVH
`define MTLS_MAP_SVH

// register indices on the serial register interface (7-bit address)
`define MTLS_ADDR_LOAD_HIST 7'h41
`define MTLS_ADDR_WAVE_0 7'h80
`define MTLS_ADDR_WAVE_1 7'h81
`define MTLS_ADDR_WAVE_2 7'h82

// reset contents: sine-wave quarter table, first three words
`define MTLS_RST_WAVE_0 32'hAAAAB554
`define MTLS_RST_WAVE_1 32'h4A9554AA
`define MTLS_RST_WAVE_2 32'h24492929
`define MTLS_RST_LOAD_HIST 32'h00000000
`define MTLS_RST_BYTE 8'h00
`define MTLS_RST_STEP 3'h0

// load-history byte lanes
`define MTLS_HIST_NEWEST 7:0
`define MTLS_HIST_FIRST 15:8
`define MTLS_HIST_SECOND 23:16
`define MTLS_HIST_THIRD 31:24

// table entry index split: word select and bit select
`define MTLS_IDX_WORD 6:5
`define MTLS_IDX_BIT 4:0
`define MTLS_WORD_0 2'h0
`define MTLS_WORD_1 2'h1
`define MTLS_WORD_2 2'h2
`define MTLS_WORD_3 2'h3

// slope select codes
`define MTLS_SLOPE_00 2'h0
`define MTLS_SLOPE_01 2'h1
`define MTLS_SLOPE_10 2'h2
`define MTLS_SLOPE_11 2'h3

// signed step values, 3-bit two's complement
`define MTLS_STEP_M1 3'h7
`define MTLS_STEP_0 3'h0
`define MTLS_STEP_P1 3'h1
`define MTLS_STEP_P2 3'h2
`define MTLS_STEP_P3 3'h3

`define MTLS_ZERO_WORD 32'h00000000

`endif

// ==== verilog/mtls_microstep_table_and_load_samples.sv ====
// Functional notes
// - top byte shows third stored filter sample
// - byte 23:16 shows second stored sample
// - byte 15:8 shows first stored sample
// - low byte shows latest load measurement
// - table bits code entry-to-entry differences
// - bit zero with slope 00 means minus one
// - other slope codes give listed steps
// - table covers quarter wave, starts elsewhere
// - filter enable bit switches sample history
// - one new measurement per full step
`timescale 1ns/1ns
`default_nettype none
`include "mtls_map.svh"

module mtls_microstep_table_and_load_samples
	import mtls_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	// register access from the serial interface decoder
	input wire mtls_reg_req_t regReq,
	output logic [31:0] regRdData,
	output logic regRdValid,
	// load measurement side
	input wire logic loadFilterEnable,
	input wire logic fullStepStrobe,
	input wire logic [7:0] loadMeasurementValue,
	// indexer lookup side
	input wire mtls_lookup_t lookup,
	output logic [2:0] stepDelta,
	output logic stepValid,
	output logic stepInRange
);

	////////////////////////////////////////////////////////////////////
	// storage

	logic [31:0] waveTableWord0_reg; // quarter-wave entries 0..31
	logic [31:0] waveTableWord1_reg; // entries 32..63
	logic [31:0] waveTableWord2_reg; // entries 64..95
	logic [7:0] loadSampleNewest_reg; // latest measurement
	logic [7:0] loadSampleFirst_reg; // filter input 1
	logic [7:0] loadSampleSecond_reg; // filter input 2
	logic [7:0] loadSampleThird_reg; // filter input 3
	logic [31:0] loadSampleHistory; // assembled read view
	logic [31:0] regRdData_next; // read mux result
	logic tableBit; // selected difference bit
	logic [1:0] lookupWord; // word select of entry
	logic [2:0] stepDelta_next; // decoded step
	logic stepInRange_next; // entry held in words 0..2

	////////////////////////////////////////////////////////////////////
	// table words: plain read/write storage with sine reset contents

	// no write mask: software always writes whole 32-bit words
	// a write of an unmapped or read-only index changes nothing here

	// word 0 write; the indexer sees it on the very next lookup
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			waveTableWord0_reg <= `MTLS_RST_WAVE_0;
		end else if (regReq.wrEn && regReq.addr == `MTLS_ADDR_WAVE_0) begin
			waveTableWord0_reg <= regReq.wdata;
		end
	end

	// word 1 write
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			waveTableWord1_reg <= `MTLS_RST_WAVE_1;
		end else if (regReq.wrEn && regReq.addr == `MTLS_ADDR_WAVE_1) begin
			waveTableWord1_reg <= regReq.wdata;
		end
	end

	// word 2 write
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			waveTableWord2_reg <= `MTLS_RST_WAVE_2;
		end else if (regReq.wrEn && regReq.addr == `MTLS_ADDR_WAVE_2) begin
			waveTableWord2_reg <= regReq.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// load sample history

	// newest byte follows every full-step measurement, filter or not;
	// it is the plain measurement read-out, so it is never gated by
	// the filter enable, only the three older bytes are
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			loadSampleNewest_reg <= `MTLS_RST_BYTE;
		end else if (fullStepStrobe) begin
			loadSampleNewest_reg <= loadMeasurementValue;
		end
	end

	// older samples shift only while filtering; cleared when off so
	// a re-enabled filter never averages stale samples from before
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			loadSampleFirst_reg <= `MTLS_RST_BYTE;
			loadSampleSecond_reg <= `MTLS_RST_BYTE;
			loadSampleThird_reg <= `MTLS_RST_BYTE;
		end else if (!loadFilterEnable) begin
			// filter off: history bytes read as zero
			loadSampleFirst_reg <= `MTLS_RST_BYTE;
			loadSampleSecond_reg <= `MTLS_RST_BYTE;
			loadSampleThird_reg <= `MTLS_RST_BYTE;
		end else if (fullStepStrobe) begin
			// filter on: age each sample by one full step
			loadSampleFirst_reg <= loadSampleNewest_reg;
			loadSampleSecond_reg <= loadSampleFirst_reg;
			loadSampleThird_reg <= loadSampleSecond_reg;
		end
	end

	// byte placement of the read-only history word
	always_comb begin
		loadSampleHistory = `MTLS_RST_LOAD_HIST;
		loadSampleHistory[`MTLS_HIST_THIRD] = loadSampleThird_reg;
		loadSampleHistory[`MTLS_HIST_SECOND] = loadSampleSecond_reg;
		loadSampleHistory[`MTLS_HIST_FIRST] = loadSampleFirst_reg;
		loadSampleHistory[`MTLS_HIST_NEWEST] = loadSampleNewest_reg;
	end

	////////////////////////////////////////////////////////////////////
	// register read path

	// a write and a read of one index in the same cycle: the read sees
	// the old word, since the mux looks at the flops before the edge
	// that stores the new one

	// read mux; unmapped indices answer zero
	always_comb begin
		case (regReq.addr)
			`MTLS_ADDR_LOAD_HIST: regRdData_next = loadSampleHistory;
			`MTLS_ADDR_WAVE_0: regRdData_next = waveTableWord0_reg;
			`MTLS_ADDR_WAVE_1: regRdData_next = waveTableWord1_reg;
			`MTLS_ADDR_WAVE_2: regRdData_next = waveTableWord2_reg;
			default: regRdData_next = `MTLS_ZERO_WORD;
		endcase
	end

	// read data held until the next read strobe
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdData <= `MTLS_ZERO_WORD;
		end else if (regReq.rdEn) begin
			regRdData <= regRdData_next;
		end
	end

	// read valid: one-cycle pulse after the strobe; it tells a fresh
	// answer apart from the held data of an older read
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdValid <= 1'h0;
		end else begin
			regRdValid <= regReq.rdEn;
		end
	end

	////////////////////////////////////////////////////////////////////
	// differential decode for the indexer; only the quarter wave is
	// coded, start values and mirroring live in the indexer

	assign lookupWord = lookup.entry[`MTLS_IDX_WORD];

	// entries of word 3 and up are held outside this block
	assign stepInRange_next = (lookupWord != `MTLS_WORD_3);

	// pick the difference bit of entry x
	always_comb begin
		case (lookupWord)
			`MTLS_WORD_0: tableBit = waveTableWord0_reg[lookup.entry[`MTLS_IDX_BIT]];
			`MTLS_WORD_1: tableBit = waveTableWord1_reg[lookup.entry[`MTLS_IDX_BIT]];
			`MTLS_WORD_2: tableBit = waveTableWord2_reg[lookup.entry[`MTLS_IDX_BIT]];
			// words past 2 decode as a zero bit; the range flag tells
			// the indexer to drop that answer
			default: tableBit = 1'h0; // word held outside this block
		endcase
	end

	// bit plus slope select gives the step from x to x+1
	always_comb begin
		case ({tableBit, lookup.slope})
			{1'h0, `MTLS_SLOPE_00}: stepDelta_next = `MTLS_STEP_M1;
			{1'h0, `MTLS_SLOPE_01}: stepDelta_next = `MTLS_STEP_0;
			{1'h0, `MTLS_SLOPE_10}: stepDelta_next = `MTLS_STEP_P1;
			{1'h0, `MTLS_SLOPE_11}: stepDelta_next = `MTLS_STEP_P2;
			{1'h1, `MTLS_SLOPE_00}: stepDelta_next = `MTLS_STEP_0;
			{1'h1, `MTLS_SLOPE_01}: stepDelta_next = `MTLS_STEP_P1;
			{1'h1, `MTLS_SLOPE_10}: stepDelta_next = `MTLS_STEP_P2;
			{1'h1, `MTLS_SLOPE_11}: stepDelta_next = `MTLS_STEP_P3;
			default: stepDelta_next = `MTLS_STEP_0;
		endcase
	end

	// registered step answer, held until the next lookup; a lookup in
	// the same cycle as a write of its word decodes the old bit, the
	// new bit applies from the next lookup onward
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			stepDelta <= `MTLS_RST_STEP;
			stepInRange <= 1'h0;
		end else if (lookup.req) begin
			stepDelta <= stepDelta_next;
			stepInRange <= stepInRange_next;
		end
	end

	// step valid: one-cycle pulse after each lookup strobe; kept apart
	// from the held delta so the indexer can spot a fresh answer
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			stepValid <= 1'h0;
		end else begin
			stepValid <= lookup.req;
		end
	end

endmodule : mtls_microstep_table_and_load_samples
`default_nettype wire

// ==== verilog/mtls_pkg.sv ====
`default_nettype none
package mtls_pkg;

	// one register access as handed over by the serial interface decoder
	typedef struct packed {
		logic wrEn; // write strobe, one cycle
		logic rdEn; // read strobe, one cycle
		logic [6:0] addr; // register index
		logic [31:0] wdata; // write data
	} mtls_reg_req_t;

	// one lookup from the indexer
	typedef struct packed {
		logic req; // lookup strobe, one cycle
		logic [6:0] entry; // entry x, step goes to x+1
		logic [1:0] slope; // slope select of the segment holding x
	} mtls_lookup_t;

endpackage : mtls_pkg
`default_nettype wire
